//--- inc/iesp_pkg.sv
// Constants for the interrupt enable and register paging block.
// Assumes a core that drives a byte-wide register access port on one clock.
package iesp_pkg;
	localparam logic [7:0] INT_EN_ADDR    = 8'ha8;
	localparam logic [7:0] INT_EN_RESET   = 8'h00;
	localparam int         BIT_GATE       = 7;
	localparam int         BIT_GPF0       = 6;
	localparam int         BIT_T2         = 5;
	localparam int         BIT_S0         = 4;
	localparam int         BIT_T1         = 3;
	localparam int         BIT_X1         = 2;
	localparam int         BIT_T0         = 1;
	localparam int         BIT_X0         = 0;
	localparam logic [7:0] PGCTL_ADDR     = 8'h96;
	localparam int         BIT_AUTOPG     = 0;
	localparam logic [7:0] PGCTL_RESET    = 8'h01;
	localparam logic [7:0] PGSEL_ADDR     = 8'h84;
	localparam logic [7:0] PGSEL_RESET    = 8'h00;
	localparam logic [7:0] PORT0_ADDR     = 8'h80;
	localparam logic [7:0] PORT1_ADDR     = 8'h90;
	localparam logic [7:0] PORT2_ADDR     = 8'ha0;
	localparam logic [7:0] PORT3_ADDR     = 8'hb0;
	localparam logic [7:0] PORT_RESET     = 8'hff;
	localparam logic [7:0] IRQ_PAGE_RESET = 8'h00;
endpackage : iesp_pkg

//--- rtl/iesp_gate.sv
// Combinational interrupt gating: masks and global gate applied to raw requests.
// Assumes the requests arrive from logic on the same clock.
`timescale 1ns/1ps
module iesp_gate (
	input  wire logic [7:0] enable_in,
	input  wire logic [5:0] req_in,
	output logic      [5:0] pend_out
);
	// Source bits follow the low six enable bits; the gate overrides them all.
	assign pend_out = enable_in[iesp_pkg::BIT_GATE] ? (req_in & enable_in[5:0]) : 6'h00;
endmodule : iesp_gate

//--- rtl/iesp_top.sv
// Interrupt enable register, page select, automatic page switch and all-page decode.
// Assumes the core sequencer pulses irq_enter_in for one cycle when it vectors,
// and irq_exit_in for one cycle on return; page restore depth is one level.
`timescale 1ns/1ps
module iesp_top (
	input  wire logic       ref_clk_in,
	input  wire logic       sys_rst_in,
	input  wire logic [7:0] addr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	input  wire logic [5:0] req_in,
	input  wire logic       irq_enter_in,
	input  wire logic [7:0] irq_page_in,
	input  wire logic       irq_exit_in,
	input  wire logic [7:0] port_pins_in,
	output logic      [7:0] rdata_out,
	output logic            hit_out,
	output logic      [5:0] pending_out,
	output logic            irq_out,
	output logic      [7:0] page_out,
	output logic      [7:0] port0_out
);
	logic [7:0] interrupt_enable_reg_ff;
	logic [7:0] page_control_reg_ff;
	logic [7:0] page_select_reg_ff;
	logic [7:0] saved_page_ff;
	logic [7:0] port0_ff;
	logic [7:0] rdata_ff;
	logic       hit_ff;
	logic [5:0] pend_ff;
	logic       irq_ff;
	logic [5:0] pend_w;
	logic [7:0] nxt_page;
	logic [7:0] rd_mux;
	logic [7:0] pins_s1_ff;
	logic [7:0] pins_s2_ff;
	logic [7:0] pins_s3_ff;
	logic [7:0] pins_ok_ff;

	// Decodes ignore the page select, so these registers are visible on every page.
	wire sel_en    = (addr_in == iesp_pkg::INT_EN_ADDR);
	wire sel_pgctl = (addr_in == iesp_pkg::PGCTL_ADDR);
	wire sel_pgsel = (addr_in == iesp_pkg::PGSEL_ADDR);
	wire sel_p0    = (addr_in == iesp_pkg::PORT0_ADDR);
	wire any_sel   = sel_en | sel_pgctl | sel_pgsel | sel_p0;
	wire auto_on   = page_control_reg_ff[iesp_pkg::BIT_AUTOPG];

	iesp_gate u_gate (
		.enable_in (interrupt_enable_reg_ff),
		.req_in    (req_in),
		.pend_out  (pend_w)
	);

	// Read data mux; port 0 reads show the filtered pins.
	assign rd_mux = sel_en    ? interrupt_enable_reg_ff :
	                sel_pgctl ? page_control_reg_ff :
	                sel_pgsel ? page_select_reg_ff :
	                sel_p0    ? pins_ok_ff : 8'h00;

	// Page on entry is the vector's page and exit restores the saved page, both only when switching is on.
	assign nxt_page = (irq_enter_in && auto_on) ? irq_page_in :
	                  (irq_exit_in && auto_on)  ? saved_page_ff :
	                  (wr_in && sel_pgsel)      ? wdata_in : page_select_reg_ff;

	// Pin inputs pass three flops; a change is taken once stages two and three agree.
	always_ff @(posedge ref_clk_in) begin
		pins_s1_ff <= port_pins_in;
		pins_s2_ff <= pins_s1_ff;
		pins_s3_ff <= pins_s2_ff;
		if (sys_rst_in) begin
			pins_ok_ff <= iesp_pkg::PORT_RESET;
		end else if (pins_s2_ff == pins_s3_ff) begin
			pins_ok_ff <= pins_s3_ff;
		end
	end

	// Register writes.
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			interrupt_enable_reg_ff <= iesp_pkg::INT_EN_RESET;
			page_control_reg_ff     <= iesp_pkg::PGCTL_RESET;
			port0_ff                <= iesp_pkg::PORT_RESET;
		end else if (wr_in) begin
			if (sel_en) begin
				interrupt_enable_reg_ff <= wdata_in;
			end
			if (sel_pgctl) begin
				page_control_reg_ff <= wdata_in & iesp_pkg::PGCTL_RESET;
			end
			if (sel_p0) begin
				port0_ff <= wdata_in;
			end
		end
	end

	// Page select and one-deep saved page for automatic switching.
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			page_select_reg_ff <= iesp_pkg::PGSEL_RESET;
			saved_page_ff      <= iesp_pkg::IRQ_PAGE_RESET;
		end else begin
			page_select_reg_ff <= nxt_page;
			if (irq_enter_in && auto_on) begin
				saved_page_ff <= page_select_reg_ff;
			end
		end
	end

	// Registered outputs; an unmapped read returns zero with hit low.
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			rdata_ff <= 8'h00;
			hit_ff   <= 1'b0;
			pend_ff  <= 6'h00;
			irq_ff   <= 1'b0;
		end else begin
			rdata_ff <= rd_in ? rd_mux : 8'h00;
			hit_ff   <= (rd_in | wr_in) & any_sel;
			pend_ff  <= pend_w;
			irq_ff   <= |pend_w;
		end
	end

	assign rdata_out   = rdata_ff;
	assign hit_out     = hit_ff;
	assign pending_out = pend_ff;
	assign irq_out     = irq_ff;
	assign page_out    = page_select_reg_ff;
	assign port0_out   = port0_ff;

	// Checks on gating, paging and decode; all but a_auto_reset and a_auto_hold look one edge on.
	property p_gate_blocks;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		!interrupt_enable_reg_ff[iesp_pkg::BIT_GATE] |=> (pending_out == 6'h00) && !irq_out;
	endproperty
	a_gate_blocks: assert property (p_gate_blocks) else $error("Pending seen with gate clear.");

	property p_gate_passes;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		interrupt_enable_reg_ff[iesp_pkg::BIT_GATE] |=>
			pending_out == ($past(req_in) & $past(interrupt_enable_reg_ff[5:0]));
	endproperty
	a_gate_passes: assert property (p_gate_passes) else $error("Pending not following masks.");

	property p_t2_mask;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(interrupt_enable_reg_ff[iesp_pkg::BIT_GATE] && req_in[iesp_pkg::BIT_T2])
			|=> pending_out[iesp_pkg::BIT_T2] == $past(interrupt_enable_reg_ff[iesp_pkg::BIT_T2]);
	endproperty
	a_t2_mask: assert property (p_t2_mask) else $error("Timer 2 mask wrong.");

	property p_auto_switch;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(irq_enter_in && auto_on) |=> page_out == $past(irq_page_in) && saved_page_ff == $past(page_out);
	endproperty
	a_auto_switch: assert property (p_auto_switch) else $error("Page not switched on entry.");

	property p_no_switch;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(irq_enter_in && !auto_on && !(wr_in && sel_pgsel)) |=> $stable(page_out);
	endproperty
	a_no_switch: assert property (p_no_switch) else $error("Page changed with switch off.");

	property p_auto_reset;
		@(posedge ref_clk_in) $fell(sys_rst_in) |-> auto_on;
	endproperty
	a_auto_reset: assert property (p_auto_reset) else $error("Auto switch not set at reset.");

	property p_auto_hold;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		$fell(auto_on) |-> $past(wr_in && sel_pgctl && !wdata_in[iesp_pkg::BIT_AUTOPG]);
	endproperty
	a_auto_hold: assert property (p_auto_hold) else $error("Auto switch cleared by itself.");

	property p_all_page;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(rd_in && sel_en) |=> hit_out && rdata_out == $past(interrupt_enable_reg_ff);
	endproperty
	a_all_page: assert property (p_all_page) else $error("Enable register missed on a page.");

	// A return with switching on puts back the page saved at entry.
	property p_exit_restore;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(irq_exit_in && auto_on && !irq_enter_in) |=> page_out == $past(saved_page_ff);
	endproperty
	a_exit_restore: assert property (p_exit_restore) else $error("Page not restored.");

	// With switching off a return must not move the page either.
	property p_exit_ignored;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(irq_exit_in && !auto_on && !irq_enter_in && !(wr_in && sel_pgsel)) |=> $stable(page_out);
	endproperty
	a_exit_ignored: assert property (p_exit_ignored) else $error("Exit moved page.");

	// A masked timer 2 request never reaches the pending set.
	property p_t2_blocked;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(req_in[iesp_pkg::BIT_T2] && !interrupt_enable_reg_ff[iesp_pkg::BIT_T2])
			|=> !pending_out[iesp_pkg::BIT_T2];
	endproperty
	a_t2_blocked: assert property (p_t2_blocked) else $error("Timer 2 leaked.");

	// The page select itself reads back whatever page is current.
	property p_pgsel_any;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(rd_in && sel_pgsel) |=> hit_out && rdata_out == $past(page_select_reg_ff);
	endproperty
	a_pgsel_any: assert property (p_pgsel_any) else $error("Page select missed.");

	// Port 0 data reads answer on every page with the filtered pins.
	property p_port_any;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(rd_in && sel_p0) |=> hit_out && rdata_out == $past(pins_ok_ff);
	endproperty
	a_port_any: assert property (p_port_any) else $error("Port read missed.");

	// Unmapped addresses get no hit and zero data.
	property p_unmapped;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		((rd_in || wr_in) && !any_sel) |=> !hit_out && rdata_out == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("Unmapped access answered.");

	// Enable register writes land whatever the page select holds.
	property p_en_write;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(wr_in && sel_en) |=> interrupt_enable_reg_ff == $past(wdata_in);
	endproperty
	a_en_write: assert property (p_en_write) else $error("Enable write lost.");
endmodule : iesp_top

//--- testbench/iesp_core_model.sv
// Behavioural model of the core sequencer that vectors on the block's irq output.
// Assumes the block's clock and reset; the bench gates acceptance of requests.
`timescale 1ns/1ps
module iesp_core_model #(
	parameter int         HOLD  = 4,
	parameter logic [7:0] VPAGE = 8'h0f
) (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       accept_in,
	input  wire logic       irq_in,
	output logic            enter_out,
	output logic            exit_out,
	output logic      [7:0] page_out
);
	logic busy_ff;
	int   cnt_ff;
	// Vector once, return HOLD+1 cycles later; no nesting, as the block saves one page only.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			busy_ff   <= 1'b0;
			cnt_ff    <= 0;
			enter_out <= 1'b0;
			exit_out  <= 1'b0;
		end else begin
			enter_out <= !busy_ff && accept_in && irq_in;
			exit_out  <= busy_ff && (cnt_ff == 0);
			if (!busy_ff && accept_in && irq_in) begin
				busy_ff <= 1'b1;
				cnt_ff  <= HOLD;
			end else if (busy_ff && cnt_ff == 0) begin
				busy_ff <= 1'b0;
			end else if (busy_ff) begin
				cnt_ff <= cnt_ff - 1;
			end
		end
	end
	assign page_out = VPAGE;
endmodule : iesp_core_model

//--- testbench/tb.sv
// Self-checking bench for the interrupt enable and register paging block.
// Assumes the package, the design and the core model are compiled first.
`timescale 1ns/1ps
module tb;
	logic        clk = 0, rst = 1, wr = 0, rd = 0, acc = 0, hit, irq, ent, ext;
	logic [7:0]  addr = 0, wd = 0, pins = 8'h5a, rdat, page, p0, vpg;
	logic [5:0]  req = 0, pend;
	int          fails = 0, samples_checked = 0;
	// Rows hold enable value, raw requests and the pending set they should give.
	logic [19:0] rows [5] = '{{8'h3f, 6'h3f, 6'h00}, {8'hbf, 6'h3f, 6'h3f},
		{8'ha0, 6'h20, 6'h20}, {8'h9f, 6'h20, 6'h00}, {8'hc0, 6'h3f, 6'h00}};

	always #20 clk = ~clk;

	iesp_top dut (.ref_clk_in(clk), .sys_rst_in(rst), .addr_in(addr), .wdata_in(wd),
		.wr_in(wr), .rd_in(rd), .req_in(req), .irq_enter_in(ent), .irq_page_in(vpg),
		.irq_exit_in(ext), .port_pins_in(pins), .rdata_out(rdat), .hit_out(hit),
		.pending_out(pend), .irq_out(irq), .page_out(page), .port0_out(p0));
	iesp_core_model core (.clk_in(clk), .rst_in(rst), .accept_in(acc), .irq_in(irq),
		.enter_out(ent), .exit_out(ext), .page_out(vpg));

	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		samples_checked++;
		if (s !== e) begin
			fails++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask : chk

	// One access per call; read data stands in the cycle after the taking edge.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		wr = w;
		rd = !w;
		addr = a;
		wd = d;
		@(negedge clk);
		wr = 0;
		rd = 0;
	endtask : xfer

	task automatic results;
		$display("checked %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : results

	// Watchdog sized well past the 112 cycles at most that the sequence needs.
	initial begin
		#40000;
		fails++;
		results();
	end

	initial begin
		repeat (10) @(negedge clk);
		rst = 0;
		chk("port0", p0, iesp_pkg::PORT_RESET);
		chk("page", page, iesp_pkg::PGSEL_RESET);
		xfer(0, iesp_pkg::INT_EN_ADDR, 0);
		chk("enable reset", rdat, iesp_pkg::INT_EN_RESET);
		xfer(0, iesp_pkg::PGCTL_ADDR, 0);
		chk("auto reset", rdat, iesp_pkg::PGCTL_RESET);
		foreach (rows[i]) begin
			xfer(1, iesp_pkg::INT_EN_ADDR, rows[i][19:12]);
			req = rows[i][11:6];
			repeat (2) @(negedge clk);
			chk("pend", {2'h0, pend}, {2'h0, rows[i][5:0]});
			chk("irq", {7'h0, irq}, {7'h0, |rows[i][5:0]});
		end
		// Unmapped access must be refused, then all-page reads under a foreign page.
		xfer(0, 8'h11, 0);
		chk("unmapped hit", {7'h0, hit}, 8'h00);
		chk("unmapped data", rdat, 8'h00);
		xfer(1, 8'h11, 8'h33);
		chk("unmapped write hit", {7'h0, hit}, 8'h00);
		xfer(1, iesp_pkg::PGSEL_ADDR, 8'h05);
		chk("page write", page, 8'h05);
		xfer(0, iesp_pkg::PGSEL_ADDR, 0);
		chk("page select read", rdat, 8'h05);
		xfer(0, iesp_pkg::INT_EN_ADDR, 0);
		chk("enable other page", rdat, 8'hc0);
		chk("enable hit", {7'h0, hit}, 8'h01);
		xfer(0, iesp_pkg::PORT0_ADDR, 0);
		chk("port0 pins", rdat, 8'h5a);
		xfer(1, iesp_pkg::PORT0_ADDR, 8'h3c);
		chk("port0 write hit", {7'h0, hit}, 8'h01);
		chk("port0 latch", p0, 8'h3c);
		// Interrupt entry switches page, return restores it.
		xfer(1, iesp_pkg::INT_EN_ADDR, 8'h82);
		req = 6'h02;
		acc = 1;
		for (int k = 0; k < 20 && page !== 8'h0f; k++) @(negedge clk);
		chk("page enter", page, 8'h0f);
		acc = 0;
		for (int k = 0; k < 20 && page !== 8'h05; k++) @(negedge clk);
		chk("page exit", page, 8'h05);
		// With the auto enable cleared entry must leave the page alone.
		xfer(1, iesp_pkg::PGCTL_ADDR, 0);
		xfer(0, iesp_pkg::PGCTL_ADDR, 0);
		chk("auto cleared", rdat, 8'h00);
		acc = 1;
		repeat (12) @(negedge clk);
		chk("page held", page, 8'h05);
		acc = 0;
		rst = 1;
		repeat (2) @(negedge clk);
		rst = 0;
		chk("page rereset", page, iesp_pkg::PGSEL_RESET);
		chk("port0 rereset", p0, iesp_pkg::PORT_RESET);
		xfer(0, iesp_pkg::PGCTL_ADDR, 0);
		chk("auto rereset", rdat, iesp_pkg::PGCTL_RESET);
		xfer(0, iesp_pkg::INT_EN_ADDR, 0);
		chk("enable rereset", rdat, iesp_pkg::INT_EN_RESET);
		results();
	end
endmodule : tb
